// *** testbench/msb_exec_monitor.sv ***
`timescale 1ns/1ps
module msb_exec_monitor (
    input wire        sys_clk,
    input wire        resetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [15:0] pm_addr,
    input wire [7:0]  pm_data,
    input wire        busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire       go = psel && penable && pready && pwrite && paddr == 8'h00 && !busy;
    wire [4:0] op = pwdata[4:0];
    sequence busy3; busy [*3] ##1 !busy; endsequence
    sequence busy2; busy [*2] ##1 !busy; endsequence
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_error: assert property (pready && (paddr > 8'h1C || paddr[1:0] != 2'b00) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");
    a_mapped_no_error: assert property (pready && paddr <= 8'h1C && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped access");
    a_pmload_three_cycles: assert property (go && op == 5'h01 |=> busy3)
        else $error("program load not three cycles");
    a_two_cycle_ops: assert property (go && op >= 5'h02 && op <= 5'h05 |=> busy2)
        else $error("two cycle op wrong length");
    a_one_cycle_ops: assert property (go && (op == 5'h00 || op > 5'h05) |=> busy ##1 !busy)
        else $error("one cycle op wrong length");
    a_idle_stays_idle: assert property (!busy && !go |=> !busy)
        else $error("busy without command");
endmodule // msb_exec_monitor

bind msb_exec msb_exec_monitor u_mon (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pm_addr(pm_addr), .pm_data(pm_data), .busy(busy));

// *** testbench/test_msb_exec.sv ***
`timescale 1ns/1ps
module test_msb_exec;
    reg         sys_clk = 1'b0;
    reg         resetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0;
    reg  [7:0]  pm_data;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        busy;
    wire [15:0] pm_addr;
    reg  [31:0] q;
    reg         e;
    reg  [8:0]  x;
    reg  [7:0]  s;
    reg  [7:0]  d;
    integer     n_errors = 0;
    integer     total_checks = 0;
    integer     i;
    integer     j;
    always #20 sys_clk = ~sys_clk;
    always @* pm_data = pm_addr[7:0] ^ 8'h3C;
    msb_exec DUT (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pm_addr(pm_addr), .pm_data(pm_data), .busy(busy));
    task test_done;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task hang;
        begin
            n_errors = n_errors + 1;
            test_done;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task xfer(input w, input [7:0] a, input [31:0] v);
        integer n;
        begin
            n = 0;
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= v;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1) begin
                n = n + 1;
                if (n > 20) hang;
                @(posedge sys_clk);
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task run(input [4:0] op, input [4:0] r, input [2:0] b, input [4:0] io, input poke);
        integer n;
        begin
            n = 0;
            xfer(1'b1, 8'h00, {3'h0, io, 5'h0, b, 3'h0, r, 3'h0, op});
            if (poke) xfer(1'b1, 8'h08, 32'h0);
            while (busy !== 1'b0) begin
                n = n + 1;
                if (n > 20) hang;
                @(posedge sys_clk);
            end
        end
    endtask
    task setr(input [4:0] r, input [7:0] v);
        begin
            xfer(1'b1, 8'h0C, {27'h0, r});
            xfer(1'b1, 8'h10, {24'h0, v});
        end
    endtask
    task getr(input [4:0] r);
        begin
            xfer(1'b1, 8'h0C, {27'h0, r});
            xfer(1'b0, 8'h10, 32'h0);
        end
    endtask
    function [8:0] shf(input [4:0] op, input [7:0] v, input c);
        case (op)
            5'h06: shf = {v, 1'b0};
            5'h07: shf = {v[0], 1'b0, v[7:1]};
            5'h08: shf = {v, c};
            5'h09: shf = {v[0], c, v[7:1]};
            default: shf = {v[0], v[7], v[7:1]};
        endcase
    endfunction
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        xfer(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0);
        xfer(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0F);
        xfer(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
        for (i = 6; i < 11; i = i + 1) begin
            for (j = 0; j < 2; j = j + 1) begin
                d = j ? 8'h80 : 8'h96;
                s = 8'hF0 | j;
                x = shf(i, d, j);
                xfer(1'b1, 8'h08, {24'h0, s});
                setr(5, d);
                run(i, 5, 0, 0, 0);
                getr(5);
                chk(q, {24'h0, x[7:0]});
                xfer(1'b0, 8'h08, 32'h0);
                chk(q, {24'h0, s[7:4], x[7] ^ x[8], x[7], x[7:0] == 8'h00, x[8]});
            end
        end
        $display("test shifts done");
        xfer(1'b1, 8'h08, 32'h5A);
        setr(6, 8'h3C);
        run(5'h0E, 6, 0, 0, 0);
        getr(6);
        chk(q, 32'hC3);
        xfer(1'b0, 8'h08, 32'h0);
        chk(q, 32'h5A);
        xfer(1'b1, 8'h08, 32'h0);
        setr(7, 8'h08);
        run(5'h0B, 7, 3, 0, 0);
        xfer(1'b0, 8'h08, 32'h0);
        chk(q, 32'h40);
        setr(8, 8'h00);
        run(5'h0C, 8, 6, 0, 0);
        getr(8);
        chk(q, 32'h40);
        xfer(1'b1, 8'h08, 32'h0);
        run(5'h0D, 0, 0, 0, 0);
        xfer(1'b0, 8'h08, 32'h0);
        chk(q, 32'h10);
        $display("test transfer flag done");
        for (i = 0; i < 8; i = i + 1) begin
            xfer(1'b1, 8'h08, 32'h0);
            run(5'h0F, 0, i, 0, 0);
            xfer(1'b0, 8'h08, 32'h0);
            chk(q, 32'h1 << i);
            xfer(1'b1, 8'h08, 32'hFF);
            run(5'h10, 0, i, 0, 0);
            xfer(1'b0, 8'h08, 32'h0);
            chk(q, 32'hFF ^ (32'h1 << i));
        end
        $display("test flags done");
        xfer(1'b1, 8'h08, 32'h2B);
        setr(3, 8'hA5);
        run(5'h02, 3, 0, 0, 0);
        xfer(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0E);
        setr(4, 8'h00);
        run(5'h03, 4, 0, 0, 0);
        getr(4);
        chk(q, 32'hA5);
        xfer(1'b0, 8'h08, 32'h0);
        chk(q, 32'h2B);
        xfer(1'b1, 8'h14, 32'h07);
        xfer(1'b1, 8'h18, 32'h00);
        run(5'h04, 0, 5, 7, 0);
        xfer(1'b0, 8'h18, 32'h0);
        chk(q, 32'h20);
        xfer(1'b1, 8'h18, 32'hFF);
        run(5'h05, 0, 5, 7, 0);
        xfer(1'b0, 8'h18, 32'h0);
        chk(q, 32'hDF);
        $display("test stack and io done");
        xfer(1'b1, 8'h08, 32'h81);
        setr(30, 8'hFF);
        setr(31, 8'h12);
        run(5'h01, 2, 0, 0, 1);
        chk({16'h0, pm_addr}, 32'h12FF);
        getr(2);
        chk(q, 32'hC3);
        getr(30);
        chk(q, 32'h00);
        getr(31);
        chk(q, 32'h13);
        xfer(1'b0, 8'h08, 32'h0);
        chk(q, 32'h81);
        xfer(1'b0, 8'h00, 32'h0);
        chk(q, 32'h01);
        run(5'h00, 0, 0, 0, 0);
        xfer(1'b0, 8'h08, 32'h0);
        chk(q, 32'h81);
        xfer(1'b0, 8'h00, 32'h0);
        chk(q, 32'h00);
        $display("test program load done");
        test_done;
    end
endmodule // test_msb_exec

// *** verilog/msb_consts.vh ***
`ifndef MSB_CONSTS_VH
`define MSB_CONSTS_VH

// APB byte offsets
`define MSB_CMD_OFS      8'h00
`define MSB_STAT_OFS     8'h04
`define MSB_FLAGS_OFS    8'h08
`define MSB_RSEL_OFS     8'h0C
`define MSB_RDATA_OFS    8'h10
`define MSB_IOSEL_OFS    8'h14
`define MSB_IODATA_OFS   8'h18
`define MSB_SP_OFS       8'h1C

// Command word fields
`define MSB_CMD_OP_LSB   0
`define MSB_CMD_OP_MSB   4
`define MSB_CMD_REG_LSB  8
`define MSB_CMD_REG_MSB  12
`define MSB_CMD_BIT_LSB  16
`define MSB_CMD_BIT_MSB  18
`define MSB_CMD_IO_LSB   24
`define MSB_CMD_IO_MSB   28

// Operation codes
`define MSB_OP_NOP       5'h00
`define MSB_OP_PMLOAD    5'h01
`define MSB_OP_PUSH      5'h02
`define MSB_OP_POP       5'h03
`define MSB_OP_IOSET     5'h04
`define MSB_OP_IOCLR     5'h05
`define MSB_OP_SHL       5'h06
`define MSB_OP_SHR       5'h07
`define MSB_OP_RCL       5'h08
`define MSB_OP_RCR       5'h09
`define MSB_OP_SAR       5'h0A
`define MSB_OP_TSTORE    5'h0B
`define MSB_OP_TLOAD     5'h0C
`define MSB_OP_SSET      5'h0D
`define MSB_OP_SWAP      5'h0E
`define MSB_OP_FSET      5'h0F
`define MSB_OP_FCLR      5'h10

// Status register bit positions
`define MSB_SR_C         0
`define MSB_SR_Z         1
`define MSB_SR_N         2
`define MSB_SR_V         3
`define MSB_SR_S         4
`define MSB_SR_H         5
`define MSB_SR_T         6
`define MSB_SR_I         7

// Execution cycle counts
`define MSB_CYC_PMLOAD   2'h3
`define MSB_CYC_TWO      2'h2
`define MSB_CYC_ONE      2'h1

// Reset values
`define MSB_FLAGS_RST    8'h00
`define MSB_SP_RST       8'h0F

`endif

// *** verilog/msb_exec.v ***
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "msb_consts.vh"

module msb_exec (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [15:0] pm_addr,
    input  wire [7:0]  pm_data,
    output reg         busy
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg  [7:0]  reg_file [0:31];
    reg  [7:0]  io_space [0:31];
    reg  [7:0]  stack_mem [0:15];

    reg         state_r;
    reg  [1:0]  cnt_r;
    reg  [4:0]  op_r;
    reg  [4:0]  rsel_op_r;
    reg  [2:0]  bit_r;
    reg  [4:0]  io_r;
    reg  [7:0]  flags_r;
    reg  [7:0]  sp_r;
    reg  [4:0]  rsel_r;
    reg  [4:0]  iosel_r;
    reg  [7:0]  pm_data_r;
    reg  [7:0]  flags_nxt;
    reg  [7:0]  sp_nxt;
    reg  [4:0]  rsel_nxt;
    reg  [4:0]  iosel_nxt;
    reg  [31:0] rdata_nxt;
    reg         err_nxt;

    wire [7:0]  opnd;
    wire [7:0]  sh_res;
    wire        sh_c;
    wire        sh_z;
    wire        sh_n;
    wire        sh_v;
    wire [15:0] zptr;
    wire        apb_setup;
    wire        apb_wr;
    wire        idle_wr;
    wire        cmd_go;
    wire        last_cyc;
    wire        wr_flags;
    wire        wr_sp;
    wire        wr_rsel;
    wire        wr_rdata;
    wire        wr_iosel;
    wire        wr_iodata;
    wire [3:0]  sp_push;
    wire [3:0]  sp_pop;

    function [1:0] op_cycles;
        input [4:0] op;
        begin
            case (op)
                `MSB_OP_PMLOAD: op_cycles = `MSB_CYC_PMLOAD;
                `MSB_OP_PUSH,
                `MSB_OP_POP,
                `MSB_OP_IOSET,
                `MSB_OP_IOCLR:  op_cycles = `MSB_CYC_TWO;
                default:        op_cycles = `MSB_CYC_ONE;
            endcase
        end
    endfunction

    function [7:0] bit_put;
        input [7:0] val;
        input [2:0] pos;
        input       b;
        reg   [7:0] m;
        begin
            m       = 8'h01 << pos;
            bit_put = b ? (val | m) : (val & ~m);
        end
    endfunction

    function op_is_shift;
        input [4:0] op;
        begin
            case (op)
                `MSB_OP_SHL,
                `MSB_OP_SHR,
                `MSB_OP_RCL,
                `MSB_OP_RCR,
                `MSB_OP_SAR: op_is_shift = 1'b1;
                default:     op_is_shift = 1'b0;
            endcase
        end
    endfunction

    assign opnd      = reg_file[rsel_op_r];
    assign zptr      = {reg_file[5'h1F], reg_file[5'h1E]};
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pready & pwrite;
    assign idle_wr   = apb_wr & (state_r == ST_IDLE);
    assign cmd_go    = idle_wr & (paddr == `MSB_CMD_OFS);
    assign wr_flags  = idle_wr & (paddr == `MSB_FLAGS_OFS);
    assign wr_sp     = idle_wr & (paddr == `MSB_SP_OFS);
    assign wr_rsel   = idle_wr & (paddr == `MSB_RSEL_OFS);
    assign wr_rdata  = idle_wr & (paddr == `MSB_RDATA_OFS);
    assign wr_iosel  = idle_wr & (paddr == `MSB_IOSEL_OFS);
    assign wr_iodata = idle_wr & (paddr == `MSB_IODATA_OFS);
    assign last_cyc  = (state_r == ST_RUN) && (cnt_r == 2'h1);
    assign sp_push   = sp_r[3:0];
    assign sp_pop    = sp_r[3:0] + 4'h1;

    msb_shift u_shift (
        .op    (op_r),
        .din   (opnd),
        .cin   (flags_r[`MSB_SR_C]),
        .res   (sh_res),
        .c_out (sh_c),
        .z_out (sh_z),
        .n_out (sh_n),
        .v_out (sh_v)
    );

    // Sequencer
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r   <= ST_IDLE;
            cnt_r     <= 2'h0;
            op_r      <= `MSB_OP_NOP;
            rsel_op_r <= 5'h00;
            bit_r     <= 3'h0;
            io_r      <= 5'h00;
            busy      <= 1'b0;
            pm_addr   <= 16'h0000;
            pm_data_r <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_go) begin
                        op_r      <= pwdata[`MSB_CMD_OP_MSB:`MSB_CMD_OP_LSB];
                        rsel_op_r <= pwdata[`MSB_CMD_REG_MSB:`MSB_CMD_REG_LSB];
                        bit_r     <= pwdata[`MSB_CMD_BIT_MSB:`MSB_CMD_BIT_LSB];
                        io_r      <= pwdata[`MSB_CMD_IO_MSB:`MSB_CMD_IO_LSB];
                        cnt_r     <= op_cycles(pwdata[`MSB_CMD_OP_MSB:`MSB_CMD_OP_LSB]);
                        state_r   <= ST_RUN;
                        busy      <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (op_r == `MSB_OP_PMLOAD && cnt_r == `MSB_CYC_PMLOAD)
                        pm_addr <= zptr;
                    if (op_r == `MSB_OP_PMLOAD && cnt_r == 2'h2)
                        pm_data_r <= pm_data;
                    if (last_cyc) begin
                        state_r <= ST_IDLE;
                        busy    <= 1'b0;
                        cnt_r   <= 2'h0;
                    end else begin
                        cnt_r <= cnt_r - 2'h1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy    <= 1'b0;
                end
            endcase
        end
    end

    // Register file, write port
    always @(posedge sys_clk) begin
        if (last_cyc) begin
            if (op_is_shift(op_r))
                reg_file[rsel_op_r] <= sh_res;
            case (op_r)
                `MSB_OP_PMLOAD: begin
                    reg_file[rsel_op_r] <= pm_data_r;
                    if (rsel_op_r != 5'h1E && rsel_op_r != 5'h1F) begin
                        reg_file[5'h1E] <= zptr[7:0] + 8'h01;
                        reg_file[5'h1F] <= (zptr[7:0] == 8'hFF) ? zptr[15:8] + 8'h01 : zptr[15:8];
                    end
                end
                `MSB_OP_POP: begin
                    reg_file[rsel_op_r] <= stack_mem[sp_pop];
                end
                `MSB_OP_TLOAD: begin
                    reg_file[rsel_op_r] <= bit_put(opnd, bit_r, flags_r[`MSB_SR_T]);
                end
                `MSB_OP_SWAP: begin
                    reg_file[rsel_op_r] <= {opnd[3:0], opnd[7:4]};
                end
                default: begin
                end
            endcase
        end else if (wr_rdata) begin
            reg_file[rsel_r] <= pwdata[7:0];
        end
    end

    // Stack and I/O space
    always @(posedge sys_clk) begin
        if (last_cyc && op_r == `MSB_OP_PUSH)
            stack_mem[sp_push] <= opnd;
        if (last_cyc && op_r == `MSB_OP_IOSET)
            io_space[io_r] <= bit_put(io_space[io_r], bit_r, 1'b1);
        else if (last_cyc && op_r == `MSB_OP_IOCLR)
            io_space[io_r] <= bit_put(io_space[io_r], bit_r, 1'b0);
        else if (wr_iodata)
            io_space[iosel_r] <= pwdata[7:0];
    end

    // Next status flags, stack pointer and selectors
    always @* begin
        flags_nxt = flags_r;
        sp_nxt    = sp_r;
        rsel_nxt  = rsel_r;
        iosel_nxt = iosel_r;
        if (last_cyc) begin
            if (op_is_shift(op_r)) begin
                flags_nxt[`MSB_SR_C] = sh_c;
                flags_nxt[`MSB_SR_Z] = sh_z;
                flags_nxt[`MSB_SR_N] = sh_n;
                flags_nxt[`MSB_SR_V] = sh_v;
            end
            case (op_r)
                `MSB_OP_PUSH: begin
                    sp_nxt = sp_r - 8'h01;
                end
                `MSB_OP_POP: begin
                    sp_nxt = sp_r + 8'h01;
                end
                `MSB_OP_TSTORE: begin
                    flags_nxt[`MSB_SR_T] = opnd[bit_r];
                end
                `MSB_OP_SSET: begin
                    flags_nxt[`MSB_SR_S] = 1'b1;
                end
                `MSB_OP_FSET: begin
                    flags_nxt[bit_r] = 1'b1;
                end
                `MSB_OP_FCLR: begin
                    flags_nxt[bit_r] = 1'b0;
                end
                default: begin
                end
            endcase
        end else begin
            if (wr_flags)
                flags_nxt = pwdata[7:0];
            if (wr_sp)
                sp_nxt = pwdata[7:0];
            if (wr_rsel)
                rsel_nxt = pwdata[4:0];
            if (wr_iosel)
                iosel_nxt = pwdata[4:0];
        end
    end

    // Status flags, stack pointer and selectors
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags_r <= `MSB_FLAGS_RST;
            sp_r    <= `MSB_SP_RST;
            rsel_r  <= 5'h00;
            iosel_r <= 5'h00;
        end else begin
            flags_r <= flags_nxt;
            sp_r    <= sp_nxt;
            rsel_r  <= rsel_nxt;
            iosel_r <= iosel_nxt;
        end
    end

    // Read data mux, taken at the setup cycle
    always @* begin
        rdata_nxt = 32'h0000_0000;
        err_nxt   = 1'b0;
        case (paddr)
            `MSB_CMD_OFS: begin
                rdata_nxt = {27'h0, op_r};
            end
            `MSB_STAT_OFS: begin
                rdata_nxt = {16'h0, flags_r, 7'h00, busy};
            end
            `MSB_FLAGS_OFS: begin
                rdata_nxt = {24'h0, flags_r};
            end
            `MSB_RSEL_OFS: begin
                rdata_nxt = {27'h0, rsel_r};
            end
            `MSB_RDATA_OFS: begin
                rdata_nxt = {24'h0, reg_file[rsel_r]};
            end
            `MSB_IOSEL_OFS: begin
                rdata_nxt = {27'h0, iosel_r};
            end
            `MSB_IODATA_OFS: begin
                rdata_nxt = {24'h0, io_space[iosel_r]};
            end
            `MSB_SP_OFS: begin
                rdata_nxt = {24'h0, sp_r};
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    // APB answer, one cycle after setup
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & err_nxt;
            if (apb_setup)
                prdata <= rdata_nxt;
        end
    end
endmodule // msb_exec

// *** verilog/msb_shift.v ***
`timescale 1ns/1ps
`include "msb_consts.vh"

module msb_shift (
    input  wire [4:0] op,
    input  wire [7:0] din,
    input  wire       cin,
    output reg  [7:0] res,
    output reg        c_out,
    output wire       z_out,
    output wire       n_out,
    output wire       v_out
);
    always @* begin
        res   = din;
        c_out = cin;
        case (op)
            `MSB_OP_SHL: begin
                res   = {din[6:0], 1'b0};
                c_out = din[7];
            end
            `MSB_OP_SHR: begin
                res   = {1'b0, din[7:1]};
                c_out = din[0];
            end
            `MSB_OP_RCL: begin
                res   = {din[6:0], cin};
                c_out = din[7];
            end
            `MSB_OP_RCR: begin
                res   = {cin, din[7:1]};
                c_out = din[0];
            end
            `MSB_OP_SAR: begin
                res   = {din[7], din[7:1]};
                c_out = din[0];
            end
            default: begin
                res   = din;
                c_out = cin;
            end
        endcase
    end

    assign z_out = (res == 8'h00);
    assign n_out = res[7];
    assign v_out = res[7] ^ c_out;
endmodule // msb_shift
